// ### logic/rpcs_sequencer.sv
// Reset sequencer, power-up timers and four-phase clock generator
//
// How it works
// - Clock divided by four into one-hot phase_1..phase_4, one clock each.
// - One pass phase_1 through phase_4 forms one instruction cycle.
// - Any reset parks the phase at phase_1; release restarts there.
// - In reset, external modes drive address strobe low, both strobes high.
// - read_strobe_n enables memory output, store_strobe_n writes memory.
// - Sixteen muxed pins carry address first, then data; upper byte too.
// - Reset cause tells power-on, pin reset and watchdog reset apart.
// - Registers reset on all resets except watchdog timeout during sleep.
// - A small register group has no reset and survives every reset.
// - Reset held while supply low; brown-out rearms except on old variant.
// - Power-up delay of 96 ms starts once power good and pin high.
// - Power-up delay counts its own RC ticks; core held while counting.
// - Oscillator settle waits 1024 periods after power-up or any exit from sleep.
// - Settle count used only in crystal or low-frequency modes.
// - Settle count advances only while oscillator amplitude is valid.
// - Power-up starts both timers together; release after both expire.
// - Wake uses settle count only; pin reset in normal run adds none.
// - Timeout and powerdown flags encode the reset or wake cause.
`timescale 1ns/10ps

module rpcs_sequencer
    import rpcs_pkg::*;
#(
    parameter logic [15:0] POWERUP_DELAY_TIMER_TICKS = POWERUP_DELAY_TIMER_TICKS_DEF
)
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 power_good,
    input  wire logic                 master_clear_n,
    input  wire logic                 rc_timer_osc,
    input  wire logic                 osc_amplitude_ok,
    input  wire logic [1:0]           osc_mode,
    input  wire logic                 legacy_variant,
    input  wire logic                 watchdog_reset,
    input  wire logic                 sleep_request,
    input  wire logic                 wake_event,
    input  wire logic                 ext_exec_mode,
    input  wire logic                 bus_request,
    input  wire logic                 bus_write,
    input  wire logic [15:0]          bus_address,
    input  wire logic [15:0]          bus_wdata,
    input  wire logic [15:0]          muxed_bus_pins_in,
    input  wire logic                 retain_we,
    input  wire logic [RETAIN_AW-1:0] retain_addr,
    input  wire logic [7:0]           retain_wdata,
    output logic                      phase_1,
    output logic                      phase_2,
    output logic                      phase_3,
    output logic                      phase_4,
    output logic                      core_hold,
    output logic                      regs_reset,
    output logic                      sleeping,
    output logic                      timeout_flag_n,
    output logic                      powerdown_flag_n,
    output logic [2:0]                reset_cause,
    output logic                      address_latch_strobe,
    output logic                      read_strobe_n,
    output logic                      store_strobe_n,
    output logic                      strobe_oe_n,
    output logic [15:0]               muxed_bus_pins_out,
    output logic                      muxed_bus_pins_oe_n,
    output logic [15:0]               bus_rdata,
    output logic [7:0]                retain_rdata
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Shared by both delay counters
    function automatic logic cnt_done(input logic [15:0] cnt,
                                      input logic [15:0] limit);
        cnt_done = (cnt >= limit);
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic        por_s1_r;
    logic        por_s2_r;
    logic        master_clear_n_s1_r;
    logic        master_clear_n_s2_r;
    logic        rc_s1_r;
    logic        rc_s2_r;
    logic        rc_s3_r;

    // Pin and supply levels settle before they may release reset
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            por_s1_r  <= 1'h0;
            por_s2_r  <= 1'h0;
            master_clear_n_s1_r <= 1'h0;
            master_clear_n_s2_r <= 1'h0;
        end
        else
        begin
            por_s1_r  <= power_good;
            por_s2_r  <= por_s1_r;
            master_clear_n_s1_r <= master_clear_n;
            master_clear_n_s2_r <= master_clear_n_s1_r;
        end
    end

    // RC ticks are edge-detected only after the second stage
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rc_s1_r <= 1'h0;
            rc_s2_r <= 1'h0;
            rc_s3_r <= 1'h0;
        end
        else
        begin
            rc_s1_r <= rc_timer_osc;
            rc_s2_r <= rc_s1_r;
            rc_s3_r <= rc_s2_r;
        end
    end

    // ****************************************************************
    // Decodes
    // ****************************************************************
    logic        rc_tick;
    logic        master_clear_n_high;
    logic        brownout;
    logic        xtal_sel;

    assign rc_tick   = rc_s2_r & ~rc_s3_r;
    assign master_clear_n_high = master_clear_n_s2_r;
    // The oldest variant never rearms reset on a falling supply
    assign brownout  = ~por_s2_r & ~legacy_variant;
    assign xtal_sel  = (osc_mode == OSC_CRYSTAL) |
                       (osc_mode == OSC_LOWFREQ);

    // ****************************************************************
    // Delay counters
    // ****************************************************************
    rpcs_state_e      state_r;
    logic             need_powerup_delay_timer_r;
    logic             need_ost_r;
    logic [15:0]      powerup_delay_timer_cnt_r;
    logic [OST_W-1:0] ost_cnt_r;
    logic             powerup_delay_timer_done;
    logic             ost_done;
    logic             timers_ok;
    logic             timing;

    assign timing    = (state_r == RPCS_TIMEOUT);
    assign powerup_delay_timer_done = cnt_done(powerup_delay_timer_cnt_r, POWERUP_DELAY_TIMER_TICKS);
    assign ost_done  = cnt_done({5'h00, ost_cnt_r}, OST_TOSC);
    // Release waits for whichever timer is longer
    assign timers_ok = (~need_powerup_delay_timer_r | powerup_delay_timer_done) &
                       (~need_ost_r | ost_done);

    // Counters clear whenever the sequencer leaves the timeout state
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            powerup_delay_timer_cnt_r <= 16'h0000;
            ost_cnt_r  <= '0;
        end
        else
        begin
            if (!timing)
                powerup_delay_timer_cnt_r <= 16'h0000;
            else if (need_powerup_delay_timer_r && rc_tick && !powerup_delay_timer_done)
                powerup_delay_timer_cnt_r <= 16'(powerup_delay_timer_cnt_r + 16'h0001);
            if (!timing)
                ost_cnt_r <= '0;
            else if (need_ost_r && osc_amplitude_ok && !ost_done)
                ost_cnt_r <= OST_W'(ost_cnt_r + 1'b1);
        end
    end

    // ****************************************************************
    // Reset sequence state machine
    // ****************************************************************
    rpcs_state_e state_nxt;
    rpcs_cause_e cause_r;
    rpcs_cause_e cause_nxt;
    logic        need_powerup_delay_timer_nxt;
    logic        need_ost_nxt;
    logic        regs_rst_r;
    logic        regs_rst_nxt;
    logic        to_nxt;
    logic        pd_nxt;

    // A pin reset during power-up keeps the pending timers alive
    always_comb
    begin
        state_nxt     = state_r;
        cause_nxt     = cause_r;
        need_powerup_delay_timer_nxt = need_powerup_delay_timer_r;
        need_ost_nxt  = need_ost_r;
        regs_rst_nxt  = regs_rst_r;
        to_nxt        = timeout_flag_n;
        pd_nxt        = powerdown_flag_n;
        if (state_r != RPCS_OFF && brownout)
        begin
            state_nxt     = RPCS_OFF;
            need_powerup_delay_timer_nxt = 1'h0;
            need_ost_nxt  = 1'h0;
            regs_rst_nxt  = 1'h1;
        end
        else if (state_r != RPCS_OFF && !master_clear_n_high)
        begin
            state_nxt    = RPCS_HOLD;
            regs_rst_nxt = 1'h1;
            if (state_r == RPCS_SLEEP)
            begin
                cause_nxt    = CAUSE_MASTER_CLEAR_N;
                to_nxt       = FLAG_SET;
                pd_nxt       = FLAG_CLR;
                need_ost_nxt = xtal_sel;
            end
            else if (state_r == RPCS_RUN)
            begin
                cause_nxt    = CAUSE_MASTER_CLEAR_N;
                to_nxt       = FLAG_SET;
                pd_nxt       = FLAG_SET;
                need_ost_nxt = 1'h0;
            end
        end
        else
        begin
            case (state_r)
                RPCS_OFF:
                begin
                    regs_rst_nxt = 1'h1;
                    if (por_s2_r && master_clear_n_high)
                    begin
                        state_nxt     = RPCS_TIMEOUT;
                        need_powerup_delay_timer_nxt = 1'h1;
                        need_ost_nxt  = xtal_sel;
                        cause_nxt     = CAUSE_POR;
                        to_nxt        = FLAG_SET;
                        pd_nxt        = FLAG_SET;
                    end
                end
                RPCS_HOLD:
                    state_nxt = RPCS_TIMEOUT;
                RPCS_TIMEOUT:
                begin
                    if (timers_ok)
                    begin
                        state_nxt     = RPCS_RUN;
                        need_powerup_delay_timer_nxt = 1'h0;
                        need_ost_nxt  = 1'h0;
                        regs_rst_nxt  = 1'h0;
                    end
                end
                RPCS_RUN:
                begin
                    if (watchdog_reset)
                    begin
                        state_nxt    = RPCS_TIMEOUT;
                        regs_rst_nxt = 1'h1;
                        need_ost_nxt = 1'h0;
                        cause_nxt    = CAUSE_WDT;
                        to_nxt       = FLAG_CLR;
                        pd_nxt       = FLAG_SET;
                    end
                    else if (sleep_request)
                    begin
                        state_nxt = RPCS_SLEEP;
                        to_nxt    = FLAG_SET;
                        pd_nxt    = FLAG_CLR;
                    end
                end
                RPCS_SLEEP:
                begin
                    // Watchdog in sleep is a resumption, not a reset
                    if (watchdog_reset)
                    begin
                        state_nxt    = RPCS_TIMEOUT;
                        regs_rst_nxt = 1'h0;
                        need_ost_nxt = xtal_sel;
                        cause_nxt    = CAUSE_WDT_SLEEP;
                        to_nxt       = FLAG_CLR;
                        pd_nxt       = FLAG_CLR;
                    end
                    else if (wake_event)
                    begin
                        state_nxt    = RPCS_TIMEOUT;
                        regs_rst_nxt = 1'h0;
                        need_ost_nxt = xtal_sel;
                        cause_nxt    = CAUSE_WAKE;
                        to_nxt       = FLAG_SET;
                        pd_nxt       = FLAG_CLR;
                    end
                end
                default:
                    state_nxt = RPCS_OFF;
            endcase
        end
    end

    // State and cause registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r          <= RPCS_OFF;
            cause_r          <= CAUSE_POR;
            need_powerup_delay_timer_r      <= 1'h0;
            need_ost_r       <= 1'h0;
            regs_rst_r       <= 1'h1;
            timeout_flag_n   <= FLAG_SET;
            powerdown_flag_n <= FLAG_SET;
        end
        else
        begin
            state_r          <= state_nxt;
            cause_r          <= cause_nxt;
            need_powerup_delay_timer_r      <= need_powerup_delay_timer_nxt;
            need_ost_r       <= need_ost_nxt;
            regs_rst_r       <= regs_rst_nxt;
            timeout_flag_n   <= to_nxt;
            powerdown_flag_n <= pd_nxt;
        end
    end

    assign reset_cause = cause_r;
    assign regs_reset  = regs_rst_r;

    // ****************************************************************
    // Phase generator and external bus strobes
    // ****************************************************************
    logic [1:0]  ph_r;
    logic [1:0]  ph_nxt;
    logic        run_nxt;
    logic        bus_act;
    logic        addr_phase;
    logic        ale_nxt;
    logic        rd_n_nxt;
    logic        wr_n_nxt;
    logic        pins_oe_n_nxt;
    logic [15:0] pins_out_nxt;
    logic        capture;

    assign run_nxt = (state_nxt == RPCS_RUN);
    // Counter only advances in steady run; any stop parks it
    assign ph_nxt  = (run_nxt && state_r == RPCS_RUN) ?
                     2'(ph_r + 2'h1) : PH_1;
    assign bus_act    = run_nxt & ext_exec_mode & bus_request;
    assign addr_phase = (ph_nxt == PH_1) | (ph_nxt == PH_2);
    // Strobe falls into phase_2 so the address is stable at the fall
    assign ale_nxt    = bus_act & (ph_nxt == PH_1);
    assign rd_n_nxt   = ~(bus_act & ~bus_write & ~addr_phase);
    assign wr_n_nxt   = ~(bus_act & bus_write & (ph_nxt == PH_3));
    assign pins_oe_n_nxt = ~(bus_act & (addr_phase | bus_write));
    // Address first, data after, on the same sixteen pins
    assign pins_out_nxt  = addr_phase ? bus_address : bus_wdata;
    assign capture    = (ph_r == PH_4) & ~read_strobe_n;

    // Phase outputs are one-hot and decoded ahead of the flop
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ph_r      <= PH_1;
            phase_1   <= 1'h1;
            phase_2   <= 1'h0;
            phase_3   <= 1'h0;
            phase_4   <= 1'h0;
            core_hold <= 1'h1;
            sleeping  <= 1'h0;
        end
        else
        begin
            ph_r      <= ph_nxt;
            phase_1   <= (ph_nxt == PH_1);
            phase_2   <= (ph_nxt == PH_2);
            phase_3   <= (ph_nxt == PH_3);
            phase_4   <= (ph_nxt == PH_4);
            core_hold <= ~run_nxt;
            sleeping  <= (state_nxt == RPCS_SLEEP);
        end
    end

    // Strobes idle at safe levels whenever the core is not running
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            address_latch_strobe <= 1'h0;
            read_strobe_n        <= 1'h1;
            store_strobe_n       <= 1'h1;
            strobe_oe_n          <= 1'h1;
            muxed_bus_pins_out   <= 16'h0000;
            muxed_bus_pins_oe_n  <= 1'h1;
            bus_rdata            <= 16'h0000;
        end
        else
        begin
            address_latch_strobe <= ale_nxt;
            read_strobe_n        <= rd_n_nxt;
            store_strobe_n       <= wr_n_nxt;
            strobe_oe_n          <= ~ext_exec_mode;
            muxed_bus_pins_out   <= pins_out_nxt;
            muxed_bus_pins_oe_n  <= pins_oe_n_nxt;
            if (capture)
                bus_rdata <= muxed_bus_pins_in;
        end
    end

    // ****************************************************************
    // Register group without reset value
    // ****************************************************************
    logic [7:0] keep_mem [0:RETAIN_DEPTH-1];

    // No reset branch on purpose: content must survive every reset
    always_ff @(posedge clock)
    begin
        if (retain_we && state_r == RPCS_RUN)
            keep_mem[retain_addr] <= retain_wdata;
    end

    // Read port; power-on content is whatever the array holds
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            retain_rdata <= 8'h00;
        else
            retain_rdata <= keep_mem[retain_addr];
    end

endmodule

// ### logic/rpcs_pkg.sv
// Constants and types shared by the reset and phase clock sequencer
package rpcs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    // Power-up delay, nominal, in milliseconds
    localparam int unsigned POWERUP_DELAY_TIMER_MS = 96;
    // Nominal rate of the internal RC timer oscillator, plain default
    localparam int unsigned RC_OSC_HZ = 100000;
    // Least time rounds up to whole RC ticks
    localparam logic [15:0] POWERUP_DELAY_TIMER_TICKS_DEF =
        16'((POWERUP_DELAY_TIMER_MS * RC_OSC_HZ + 999) / 1000);
    // Oscillator settle length in oscillator periods
    localparam logic [15:0] OST_TOSC = 16'h0400;
    localparam int unsigned OST_W = 11;

    // ****************************************************************
    // Oscillator configuration codes
    // ****************************************************************
    localparam logic [1:0] OSC_CRYSTAL  = 2'h0;
    localparam logic [1:0] OSC_LOWFREQ  = 2'h1;
    localparam logic [1:0] OSC_EXTCLOCK = 2'h2;
    localparam logic [1:0] OSC_RESCAP   = 2'h3;

    // ****************************************************************
    // Phase indices and reset-cause flag values
    // ****************************************************************
    localparam logic [1:0] PH_1 = 2'h0;
    localparam logic [1:0] PH_2 = 2'h1;
    localparam logic [1:0] PH_3 = 2'h2;
    localparam logic [1:0] PH_4 = 2'h3;
    localparam logic FLAG_SET = 1'h1;
    localparam logic FLAG_CLR = 1'h0;

    // Depth of the register group that holds no reset value
    localparam int unsigned RETAIN_DEPTH = 4;
    localparam int unsigned RETAIN_AW = 2;

    typedef enum logic [2:0] {
        RPCS_OFF     = 3'h0,
        RPCS_HOLD    = 3'h1,
        RPCS_TIMEOUT = 3'h2,
        RPCS_RUN     = 3'h3,
        RPCS_SLEEP   = 3'h4
    } rpcs_state_e;

    typedef enum logic [2:0] {
        CAUSE_POR       = 3'h0,
        CAUSE_MASTER_CLEAR_N      = 3'h1,
        CAUSE_WDT       = 3'h2,
        CAUSE_WDT_SLEEP = 3'h3,
        CAUSE_WAKE      = 3'h4
    } rpcs_cause_e;

endpackage

// ### tb/rpcs_sva.sv
// Port-level assertions for the reset and phase clock sequencer
`timescale 1ns/10ps
module rpcs_sva (
    input logic clock, rst, power_good, master_clear_n, legacy_variant,
    input logic ext_exec_mode, phase_1, phase_2, phase_3, phase_4,
    input logic core_hold, address_latch_strobe, read_strobe_n,
    input logic store_strobe_n, muxed_bus_pins_oe_n
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Two running cycles in a row
    sequence s_run2;
        !core_hold ##1 !core_hold;
    endsequence
    a_phase_onehot: assert property (
        $onehot({phase_1, phase_2, phase_3, phase_4}))
        else $error("phase strobes not one-hot");
    a_phase_step: assert property (phase_1 ##0 s_run2 |-> phase_2)
        else $error("phase_2 did not follow phase_1");
    a_cycle_wrap: assert property (phase_4 |=> phase_1)
        else $error("phase_1 did not follow phase_4");
    a_hold_phase: assert property (core_hold |-> phase_1)
        else $error("phase not parked while held");
    a_hold_strobes: assert property (
        core_hold && $past(core_hold) && ext_exec_mode && $past(ext_exec_mode)
        |-> !address_latch_strobe && read_strobe_n && store_strobe_n)
        else $error("bus strobes not safe while held");
    a_read_window: assert property (
        !read_strobe_n |-> (phase_3 || phase_4) && muxed_bus_pins_oe_n)
        else $error("read strobe outside phases 3 and 4");
    a_write_window: assert property (!store_strobe_n |->
        phase_3 && !muxed_bus_pins_oe_n ##1 store_strobe_n)
        else $error("write strobe outside phase_3");
    a_addr_fall: assert property (
        $fell(address_latch_strobe) |-> phase_2 && !muxed_bus_pins_oe_n)
        else $error("address not driven at strobe fall");
    a_pin_hold: assert property (!master_clear_n [*4] |=> core_hold)
        else $error("pin reset did not hold core");
    a_supply_hold: assert property (
        (!power_good && !legacy_variant) [*4] |=> core_hold)
        else $error("low supply did not hold core");
endmodule
bind rpcs_sequencer rpcs_sva i_rpcs_sva (.*);

// ### tb/rpcs_partner.sv
// External reset source and multiplexed-bus memory
`timescale 1ns/10ps
module rpcs_partner (
    input  logic        supply_ok, pin_reset_req, address_latch_strobe,
    input  logic        read_strobe_n, store_strobe_n,
    input  logic [15:0] muxed_bus_pins_out,
    output logic        master_clear_n,
    output logic [15:0] muxed_bus_pins_in
);
    logic [15:0] mem [8];
    logic [15:0] addr_q, last_q;
    // Pin stays low while supply is out of spec
    assign master_clear_n = supply_ok && !pin_reset_req;
    // Address captured on the strobe fall
    always @(negedge address_latch_strobe) addr_q = muxed_bus_pins_out;
    always @(posedge store_strobe_n) mem[addr_q[2:0]] = muxed_bus_pins_out;
    // Released bus shows inverted data so a late sample cannot pass
    always @(negedge read_strobe_n) last_q = mem[addr_q[2:0]];
    assign muxed_bus_pins_in = read_strobe_n ? ~last_q : last_q;
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the reset and phase clock sequencer
`timescale 1ns/10ps
module tb_top;
    import rpcs_pkg::*;
    localparam logic [15:0] TICKS = 16'h0008;
    // Expected {flags, cause, saw reset} per event
    localparam logic [5:0] EXP [5] = '{6'h06, 6'h28, 6'h23, 6'h15, 6'h33};
    logic clock, rst, power_good, master_clear_n, rc_timer_osc, saw_rr;
    logic osc_amplitude_ok, legacy_variant, watchdog_reset, sleep_request;
    logic wake_event, ext_exec_mode, bus_request, bus_write, retain_we;
    logic pin_reset_req, phase_1, phase_2, phase_3, phase_4, core_hold;
    logic regs_reset, sleeping, timeout_flag_n, powerdown_flag_n;
    logic address_latch_strobe, read_strobe_n, store_strobe_n, strobe_oe_n;
    logic muxed_bus_pins_oe_n, supply_ok;
    logic [1:0] osc_mode, retain_addr;
    logic [2:0] reset_cause;
    logic [7:0] retain_wdata, retain_rdata;
    logic [15:0] bus_address, bus_wdata, muxed_bus_pins_in;
    logic [15:0] muxed_bus_pins_out, bus_rdata;
    int n_mismatch, samples_checked, n;
    rpcs_sequencer #(.POWERUP_DELAY_TIMER_TICKS(TICKS)) i_rpcs_sequencer (.*);
    // Supply seen by the reset source, apart from the detector level
    rpcs_partner i_rpcs_partner (.supply_ok(supply_ok), .*);
    // ****************
    // Clocks and monitors
    // ****************
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always #230 rc_timer_osc = ~rc_timer_osc; // Unrelated to clock
    always @(posedge clock) if (regs_reset) saw_rr <= 1'b1;
    // ****************
    // Tasks
    // ****************
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    // Bounded wait for the core to run; n holds cycles waited
    task automatic wait_run(int lim);
        n = 0;
        while (core_hold !== 1'b0 && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask
    // One instruction cycle on the external bus
    task automatic bus(logic wr, logic [15:0] a, logic [15:0] d);
        for (int i = 0; i < 8 && phase_4 !== 1'b1; i++) tick(1);
        {bus_write, bus_address, bus_wdata, bus_request} = {wr, a, d, 1'b1};
        tick(1);
        check("address strobe", 16'(address_latch_strobe), 16'h1);
        check("address out", muxed_bus_pins_out, a);
        tick(3);
        // Dropped before the next phase_1 so no second cycle starts
        bus_request = 1'b0;
        tick(1);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial
    begin
        {rst, power_good, osc_amplitude_ok, ext_exec_mode, supply_ok} = 5'h1f;
        {rc_timer_osc, pin_reset_req, legacy_variant, watchdog_reset} = 4'h0;
        {sleep_request, wake_event, bus_request, bus_write, retain_we} = 5'h0;
        {bus_address, bus_wdata, retain_addr, retain_wdata} = '0;
        {osc_mode, saw_rr, n_mismatch, samples_checked} = {OSC_EXTCLOCK, 65'h0};
        tick(4);
        rst = 1'b0;
        wait_run(200);
        check("power-up length", 16'(n >= 30 && n < 200), 16'h1);
        check("power-up flags", {reset_cause, timeout_flag_n, powerdown_flag_n}, 16'h3);
        check("first phase", 16'(phase_1), 16'h1);
        check("strobe drive", 16'(strobe_oe_n), 16'h0);
        for (int k = 1; k < 5; k++)
        begin
            tick(1);
            check("phase", {phase_4, phase_3, phase_2, phase_1}, 16'h1 << (k % 4));
        end
        bus(1'b1, 16'h0003, 16'ha5c3);
        bus(1'b0, 16'h0003, 16'h0000);
        check("read data", bus_rdata, 16'ha5c3);
        {retain_we, retain_addr, retain_wdata} = {1'b1, 2'h2, 8'h5a};
        tick(1);
        retain_we = 1'b0;
        // Watchdog, wake and pin reset from sleep, then watchdog and pin reset from run
        for (int k = 0; k < 5; k++)
        begin
            if (k < 3)
            begin
                pulse(sleep_request);
                check("sleep", {sleeping, timeout_flag_n, powerdown_flag_n}, 16'h6);
            end
            tick(2);
            saw_rr = 1'b0;
            if (k == 0 || k == 3) pulse(watchdog_reset);
            else if (k == 1) pulse(wake_event);
            else
            begin
                pin_reset_req = 1'b1;
                tick(4);
                pin_reset_req = 1'b0;
            end
            wait_run(50);
            check("quick release", 16'(n < 8), 16'h1);
            check("exit", {timeout_flag_n, powerdown_flag_n, reset_cause, saw_rr}, 16'(EXP[k]));
        end
        check("kept register", 16'(retain_rdata), 16'h5a);
        {legacy_variant, power_good} = 2'h2;
        tick(6);
        check("old variant runs", 16'(core_hold), 16'h0);
        {legacy_variant, osc_mode, osc_amplitude_ok, supply_ok} = {1'b0, OSC_CRYSTAL, 2'h0};
        tick(6);
        check("brown-out hold", 16'(core_hold), 16'h1);
        {power_good, supply_ok} = 2'h3;
        tick(100);
        check("settle gated", 16'(core_hold), 16'h1);
        osc_amplitude_ok = 1'b1;
        wait_run(1100);
        check("settle length", 16'(n >= 1018 && n <= 1030), 16'h1);
        summarize();
    end
    // Hang guard well past the expected run length
    initial
    begin
        #500000;
        n_mismatch++;
        summarize();
    end
endmodule
